// >>> common/spi_port_pkg.sv
// shared constants and types for the serial status and data port
package spi_port_pkg;
    localparam logic [7:0] ADDR_CTRL  = 8'hC3;
    localparam logic [7:0] ADDR_STAT  = 8'hC4;
    localparam logic [7:0] ADDR_DATA  = 8'hC5;
    localparam logic [7:0] CTRL_RESET = 8'h14;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam int STAT_DONE_BIT  = 7;
    localparam int STAT_OVR_BIT   = 5;
    localparam int STAT_MODE_FAULT_FLAG_BIT  = 4;
    localparam int STAT_TXE_BIT   = 3;
    localparam int STAT_LSB_BIT   = 2;
    localparam int STAT_TXEIE_BIT = 1;
    localparam int STAT_MODIE_BIT = 0;
    localparam logic [4:0] MASTER_LAST_EDGE = 5'h0F;
    localparam logic [4:0] SLAVE_LAST_BIT   = 5'h07;
    localparam logic [2:0] RATE_FASTEST = 3'h1;
    localparam logic [2:0] RATE_SLOWEST = 3'h6;

    typedef struct packed {
        logic rate_select_2;
        logic peripheral_enable;
        logic ss_disable;
        logic master_select;
        logic clock_polarity_select;
        logic clock_phase_select;
        logic rate_select_1;
        logic rate_select_0;
    } ctrl_t;

    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic ss_n;
    } pins_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_XFER = 1'b1
    } state_t;
endpackage

// >>> hdl/spi_sync2.sv
// two-flop synchroniser for a group of pin levels
`timescale 1ns/10ps
`default_nettype none
module spi_sync2 #(
    parameter int W = 4
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] din,
    output var  logic [W-1:0] dout
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            meta_q <= '0;
            dout   <= '0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule // spi_sync2
`default_nettype wire

// >>> hdl/spi_rate_div.sv
// half-period tick generator for the master serial clock
`timescale 1ns/10ps
`default_nettype none
module spi_rate_div (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       run,
    input  wire logic [2:0] rate,
    output var  logic       tick
);
    logic [2:0] code;
    logic [6:0] half;
    logic [6:0] cnt_q;
    logic [6:0] cnt_d;
    logic       tick_d;

    always_comb begin
        // reserved codes fall back to the nearest legal rate
        code = rate;
        if (rate < spi_port_pkg::RATE_FASTEST) begin
            code = spi_port_pkg::RATE_FASTEST;
        end else if (rate > spi_port_pkg::RATE_SLOWEST) begin
            code = spi_port_pkg::RATE_SLOWEST;
        end
        half   = 7'(7'h01 << code);
        cnt_d  = 7'h00;
        tick_d = 1'b0;
        if (run) begin
            if (cnt_q >= half - 7'h01) begin
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 7'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_q <= 7'h00;
            tick  <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick  <= tick_d;
        end
    end
endmodule // spi_rate_div
`default_nettype wire

// >>> hdl/spi_status_data_port.sv
// serial peripheral port: control, status, data and shift engine
`timescale 1ns/10ps
`default_nettype none
module spi_status_data_port (
    input  wire logic       REF_CLK,
    input  wire logic       RSTN,
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output var  logic [7:0] RDATA,
    input  wire logic       SCK_I,
    output var  logic       SCK_O,
    output var  logic       SCK_OE,
    input  wire logic       MOSI_I,
    output var  logic       MOSI_O,
    output var  logic       MOSI_OE,
    input  wire logic       MISO_I,
    output var  logic       MISO_O,
    output var  logic       MISO_OE,
    input  wire logic       SS_N_I,
    output var  logic       IRQ,
    output var  logic       WR_OVERFLOW
);
    spi_port_pkg::pins_t  pins_s;
    spi_port_pkg::ctrl_t  ctrl_q, ctrl_d;
    spi_port_pkg::state_t state_q, state_d;
    logic       lsb_q, lsb_d, txeie_q, txeie_d, modie_q, modie_d;
    logic       done_q, done_d, ovr_q, ovr_d, mode_fault_flag_q, mode_fault_flag_d;
    logic       txe_q, txe_d, arm_q, arm_d, out_q, out_d;
    logic       sck_q, sck_d, sckp_q, sckp_d, wovf_q, wovf_d;
    logic       irq_d, sck_oe_d, miso_oe_d;
    logic [7:0] sh_q, sh_d, rx_q, rx_d, rdata_d;
    logic [4:0] cnt_q, cnt_d;
    logic       tick, rd_stat, wr_data, rd_data, fault_now, finish;
    logic       edge_now, lead, sample, new_sck, in_bit, master, en;

    spi_sync2 #(.W(4)) u_sync (
        .clk  (REF_CLK),
        .rstn (RSTN),
        .din  ({SCK_I, MOSI_I, MISO_I, SS_N_I}),
        .dout (pins_s)
    );

    spi_rate_div u_div (
        .clk  (REF_CLK),
        .rstn (RSTN),
        .run  (master && state_q == spi_port_pkg::ST_XFER),
        .rate ({ctrl_q.rate_select_2, ctrl_q.rate_select_1,
                ctrl_q.rate_select_0}),
        .tick (tick)
    );

    always_comb begin
        master  = ctrl_q.master_select;
        en      = ctrl_q.peripheral_enable;
        rd_stat = RD && ADDR == spi_port_pkg::ADDR_STAT;
        rd_data = RD && ADDR == spi_port_pkg::ADDR_DATA;
        wr_data = WR && ADDR == spi_port_pkg::ADDR_DATA;
        ctrl_d  = ctrl_q;
        state_d = state_q;
        lsb_d   = lsb_q;
        txeie_d = txeie_q;
        modie_d = modie_q;
        done_d  = done_q;
        ovr_d   = ovr_q;
        mode_fault_flag_d  = mode_fault_flag_q;
        txe_d   = txe_q;
        arm_d   = arm_q;
        out_d   = out_q;
        sck_d   = sck_q;
        sckp_d  = pins_s.sck;
        wovf_d  = wovf_q;
        sh_d    = sh_q;
        rx_d    = rx_q;
        cnt_d   = cnt_q;
        finish  = 1'b0;
        // register writes; control and status writes take effect even mid-transfer
        if (WR && ADDR == spi_port_pkg::ADDR_CTRL) begin
            ctrl_d = spi_port_pkg::ctrl_t'(WDATA);
        end else if (WR && ADDR == spi_port_pkg::ADDR_STAT) begin
            lsb_d   = WDATA[spi_port_pkg::STAT_LSB_BIT];
            txeie_d = WDATA[spi_port_pkg::STAT_TXEIE_BIT];
            modie_d = WDATA[spi_port_pkg::STAT_MODIE_BIT];
        end
        if (wr_data) begin
            if (state_q == spi_port_pkg::ST_XFER) begin
                wovf_d = 1'b1;
            end else begin
                // no holding buffer: the byte goes straight in
                sh_d  = WDATA;
                txe_d = 1'b0;
                out_d = lsb_q ? WDATA[0] : WDATA[7];
            end
        end
        // clears follow the write-overflow set, so only a same-cycle fault, overrun or done still sets
        if (rd_stat) begin
            mode_fault_flag_d = 1'b0;
            ovr_d  = 1'b0;
            wovf_d = 1'b0;
            arm_d  = 1'b1;
        end
        if ((rd_data || wr_data) && arm_q) begin
            done_d = 1'b0;
            arm_d  = 1'b0;
        end
        // shift engine
        new_sck  = master ? ~sck_q : pins_s.sck;
        edge_now = master ? tick : (pins_s.sck != sckp_q);
        lead     = new_sck != ctrl_q.clock_polarity_select;
        sample   = edge_now && (lead ^ ctrl_q.clock_phase_select);
        in_bit   = master ? pins_s.miso : pins_s.mosi;
        fault_now = en && !ctrl_q.ss_disable && (master ? !pins_s.ss_n
                    : (pins_s.ss_n && state_q == spi_port_pkg::ST_XFER
                       && cnt_q != 5'h00));
        case (state_q)
            spi_port_pkg::ST_IDLE: begin
                cnt_d = 5'h00;
                if (master) begin
                    sck_d = ctrl_q.clock_polarity_select;
                end
                if (en && master && !txe_q && !fault_now) begin
                    state_d = spi_port_pkg::ST_XFER;
                end else if (en && !master && !pins_s.ss_n) begin
                    state_d = spi_port_pkg::ST_XFER;
                end
            end
            spi_port_pkg::ST_XFER: begin
                // select rising between bytes ends the frame, no fault
                if (!master && pins_s.ss_n) begin
                    state_d = spi_port_pkg::ST_IDLE;
                end
                if (edge_now) begin
                    if (master) begin
                        sck_d = new_sck;
                    end
                    if (sample) begin
                        sh_d = lsb_q ? {in_bit, sh_q[7:1]}
                                     : {sh_q[6:0], in_bit};
                    end else begin
                        out_d = lsb_q ? sh_q[0] : sh_q[7];
                    end
                    if (master || sample) begin
                        cnt_d = cnt_q + 5'h01;
                        finish = cnt_q == (master
                            ? spi_port_pkg::MASTER_LAST_EDGE
                            : spi_port_pkg::SLAVE_LAST_BIT);
                    end
                end
                if (finish) begin
                    state_d = spi_port_pkg::ST_IDLE;
                    txe_d   = 1'b1;
                    if (done_q) begin
                        ovr_d = 1'b1;
                    end else begin
                        rx_d   = sh_d;
                        done_d = 1'b1;
                    end
                end
                if (!en) begin
                    // dropping enable kills the byte in flight
                    state_d = spi_port_pkg::ST_IDLE;
                    txe_d   = 1'b1;
                end
            end
            default: state_d = spi_port_pkg::ST_IDLE;
        endcase
        if (fault_now) begin
            mode_fault_flag_d  = 1'b1;
            state_d = spi_port_pkg::ST_IDLE;
            txe_d   = 1'b1;
            if (master) begin
                ctrl_d.peripheral_enable = 1'b0;
            end
        end
        irq_d = (mode_fault_flag_q && modie_q)
              || (txeie_q ? txe_q : done_q);
        sck_oe_d  = master && en;
        miso_oe_d = !master && en && !pins_s.ss_n;
        rdata_d   = 8'h00;
        if (RD && ADDR == spi_port_pkg::ADDR_CTRL) begin
            rdata_d = ctrl_q;
        end else if (rd_stat) begin
            rdata_d = {done_q, 1'b0, ovr_q, mode_fault_flag_q,
                       txe_q, lsb_q, txeie_q, modie_q};
        end else if (rd_data) begin
            rdata_d = rx_q;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            ctrl_q  <= spi_port_pkg::ctrl_t'(spi_port_pkg::CTRL_RESET);
            state_q <= spi_port_pkg::ST_IDLE;
            lsb_q   <= 1'b0;
            txeie_q <= 1'b0;
            modie_q <= 1'b0;
            done_q  <= 1'b0;
            ovr_q   <= 1'b0;
            mode_fault_flag_q  <= 1'b0;
            txe_q   <= 1'b1;
            arm_q   <= 1'b0;
            out_q   <= 1'b0;
            sck_q   <= 1'b0;
            sckp_q  <= 1'b0;
            wovf_q  <= 1'b0;
            sh_q    <= spi_port_pkg::DATA_RESET;
            rx_q    <= spi_port_pkg::DATA_RESET;
            cnt_q   <= 5'h00;
            RDATA   <= 8'h00;
            IRQ     <= 1'b0;
            SCK_O   <= 1'b0;
            SCK_OE  <= 1'b0;
            MOSI_O  <= 1'b0;
            MOSI_OE <= 1'b0;
            MISO_O  <= 1'b0;
            MISO_OE <= 1'b0;
            WR_OVERFLOW <= 1'b0;
        end else begin
            ctrl_q  <= ctrl_d;
            state_q <= state_d;
            lsb_q   <= lsb_d;
            txeie_q <= txeie_d;
            modie_q <= modie_d;
            done_q  <= done_d;
            ovr_q   <= ovr_d;
            mode_fault_flag_q  <= mode_fault_flag_d;
            txe_q   <= txe_d;
            arm_q   <= arm_d;
            out_q   <= out_d;
            sck_q   <= sck_d;
            sckp_q  <= sckp_d;
            wovf_q  <= wovf_d;
            sh_q    <= sh_d;
            rx_q    <= rx_d;
            cnt_q   <= cnt_d;
            RDATA   <= rdata_d;
            IRQ     <= irq_d;
            SCK_O   <= sck_d;
            SCK_OE  <= sck_oe_d;
            MOSI_O  <= out_d;
            MOSI_OE <= sck_oe_d;
            MISO_O  <= out_d;
            MISO_OE <= miso_oe_d;
            WR_OVERFLOW <= wovf_d;
        end
    end

    a_master_fault: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        fault_now && master |=> mode_fault_flag_q && !ctrl_q.peripheral_enable)
        else $error("master fault did not clear enable");
    a_fault_clear: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        rd_stat && !fault_now |=> !mode_fault_flag_q)
        else $error("status read left fault flag set");
    a_slave_ignore: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        !master && pins_s.ss_n && !ctrl_q.ss_disable
        |=> state_q == spi_port_pkg::ST_IDLE)
        else $error("slave ran with select high");
    a_load_order: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        wr_data && state_q == spi_port_pkg::ST_IDLE && !fault_now
        |=> !txe_q && sh_q == $past(WDATA)
            && out_q == (lsb_q ? sh_q[0] : sh_q[7]))
        else $error("data write did not load shifter");
    a_done_mask: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        txeie_q && !txe_q && done_q && !(mode_fault_flag_q && modie_q)
        |=> !IRQ)
        else $error("done raised interrupt while masked");
    a_empty_irq: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        txeie_q && txe_q |=> IRQ)
        else $error("empty interrupt missing");
    a_keep_older: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        finish && done_q |=> ovr_q && rx_q == $past(rx_q))
        else $error("overrun overwrote receive buffer");
    a_done_set: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        finish && !done_q |=> done_q && txe_q && rx_q == $past(sh_d))
        else $error("byte end did not set done");
    a_abort_now: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        state_q == spi_port_pkg::ST_XFER && !en
        |=> state_q == spi_port_pkg::ST_IDLE && txe_q)
        else $error("disable did not abort transfer");
    a_overflow: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        wr_data && state_q == spi_port_pkg::ST_XFER |=> WR_OVERFLOW)
        else $error("mid-transfer write not flagged");
    a_rx_read: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        rd_data |=> RDATA == $past(rx_q))
        else $error("data read not from receive buffer");
endmodule // spi_status_data_port
`default_nettype wire

// >>> test/spi_far_model.sv
// far-side serial slave model used while the port is master
`timescale 1ns/10ps
`default_nettype none
module spi_far_model (
    input  wire logic       clk,
    input  wire logic       sel_n,
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic [7:0] tx,
    output var  logic       miso,
    output var  logic [7:0] rx
);
    logic [7:0] sh;
    initial begin
        miso = 1'b0;
        rx = 8'h00;
        sh = 8'h00;
    end
    // released line flips so a stale bit can never pass
    always @(posedge clk) begin
        if (sel_n) begin
            miso <= ~miso;
        end
    end
    always @(negedge sel_n) begin
        sh = tx;
        miso = tx[7];
    end
    // msb first always: bit order is judged on the port side
    always @(posedge sck) begin
        if (!sel_n) begin
            rx = {rx[6:0], mosi};
        end
    end
    always @(negedge sck) begin
        if (!sel_n) begin
            sh = {sh[6:0], 1'b0};
            miso = sh[7];
        end
    end
endmodule // spi_far_model
`default_nettype wire

// >>> test/spi_status_data_port_tb.sv
// self-checking bench for the serial status and data port
`timescale 1ns/10ps
`default_nettype none
module spi_status_data_port_tb;
    localparam logic [7:0] CT_A = spi_port_pkg::ADDR_CTRL;
    localparam logic [7:0] ST_A = spi_port_pkg::ADDR_STAT;
    localparam logic [7:0] DT_A = spi_port_pkg::ADDR_DATA;
    logic       clk, rstn, wr, rd, ss_n, tsck, tmosi, psel_n, pmiso;
    logic       sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, irq, ovf;
    logic [7:0] addr, wdata, rdata, ptx, prx, d, p, cfg;
    int         miscompares, n_tests;
    wire logic  sck_w  = sck_oe ? sck_o : tsck;
    wire logic  mosi_w = mosi_oe ? mosi_o : tmosi;
    wire logic  miso_w = miso_oe ? miso_o : pmiso;

    spi_status_data_port DUT (.REF_CLK(clk), .RSTN(rstn), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .SCK_I(sck_w),
        .SCK_O(sck_o), .SCK_OE(sck_oe), .MOSI_I(mosi_w), .MOSI_O(mosi_o),
        .MOSI_OE(mosi_oe), .MISO_I(miso_w), .MISO_O(miso_o),
        .MISO_OE(miso_oe), .SS_N_I(ss_n), .IRQ(irq), .WR_OVERFLOW(ovf));
    spi_far_model far (.clk(clk), .sel_n(psel_n), .sck(sck_w),
        .mosi(mosi_w), .tx(ptx), .miso(pmiso), .rx(prx));

    function automatic logic [7:0] rev8(input logic [7:0] x);
        for (int i = 0; i < 8; i++)
            rev8[i] = x[7-i];
    endfunction
    // flags done, overrun, fault, empty over the three software bits
    function automatic logic [7:0] st(input logic [3:0] f,
                                      input logic [2:0] lo);
        return {f[3], 1'b0, f[2:0], lo};
    endfunction
    task automatic chk(input string what, input logic [7:0] e,
                       input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic bw(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input string what, input logic [7:0] a,
                        input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(what, e, rdata);
    endtask
    task automatic wirq(input logic lvl);
        int n;
        n = 0;
        while (irq !== lvl && n < 3000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("irq level", {7'h0, lvl}, {7'h0, irq});
    endtask
    task automatic mx(input logic [7:0] v, input logic [7:0] q,
                      input logic [7:0] c, input logic fin);
        ptx <= q;
        @(posedge clk);
        psel_n <= 1'b0;
        bw(DT_A, v);
        if (fin) rchk("busy status", ST_A, st(4'h0, c[2:0]));
        if (c[1]) wirq(1'b0);
        wirq(1'b1);
        psel_n <= 1'b1;
        chk("far rx", c[2] ? rev8(v) : v, prx);
        if (fin) begin
            rchk("done status", ST_A, st(4'h9, c[2:0]));
            rchk("rx byte", DT_A, c[2] ? rev8(q) : q);
            rchk("done clear", ST_A, st(4'h1, c[2:0]));
        end
    endtask
    // clock_phase_select 1: launch on leading edge, link clock still outside frames when s is 0
    task automatic sl(input logic [7:0] v, input int n, input logic s);
        ss_n <= ~s;
        repeat (8) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            tmosi <= v[7-i];
            tsck <= 1'b1;
            repeat (4) @(posedge clk);
            tsck <= 1'b0;
            repeat (4) @(posedge clk);
        end
        ss_n <= 1'b1;
        tmosi <= ~tmosi;
        repeat (8) @(posedge clk);
    endtask
    task automatic conclude;
        $display("tests %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #2000000;
        miscompares++;
        conclude();
    end
    initial begin
        {rstn, wr, rd, tsck, tmosi} = 5'h00;
        {ss_n, psel_n} = 2'b11;
        {addr, wdata, ptx} = 24'h000000;
        miscompares = 0;
        n_tests = 0;
        void'($urandom(3885));
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        rchk("reset status", ST_A, 8'h08);
        rchk("reset ctrl", CT_A, 8'h14);
        bw(8'h10, 8'hFF);
        rchk("unmapped", 8'h10, 8'h00);
        bw(ST_A, 8'hFF);
        rchk("sw bits", ST_A, 8'h0F);
        chk("empty irq", 8'h01, {7'h0, irq});
        bw(CT_A, 8'h53);
        rchk("ctrl", CT_A, 8'h53);
        $display("end registers");
        for (int k = 0; k < 6; k++) begin
            d = 8'($urandom);
            p = 8'($urandom);
            cfg = {5'h0, 1'($urandom), 2'b00};
            bw(ST_A, cfg);
            mx(d, p, cfg, 1'b1);
        end
        $display("end transfers");
        bw(ST_A, 8'h02);
        mx(8'h11, 8'hE7, 8'h02, 1'b0);
        mx(8'h22, 8'h18, 8'h02, 1'b0);
        rchk("overrun", ST_A, st(4'hD, 3'h2));
        rchk("kept byte", DT_A, 8'hE7);
        rchk("flags clear", ST_A, st(4'h1, 3'h2));
        chk("empty irq", 8'h01, {7'h0, irq});
        bw(ST_A, 8'h00);
        @(posedge clk);
        #1;
        chk("masked irq", 8'h00, {7'h0, irq});
        $display("end overrun");
        ptx <= 8'h5A;
        @(posedge clk);
        psel_n <= 1'b0;
        bw(DT_A, 8'hC3);
        bw(DT_A, 8'h3C);
        @(posedge clk);
        #1;
        chk("overflow", 8'h01, {7'h0, ovf});
        bw(CT_A, 8'h13);
        psel_n <= 1'b1;
        rchk("abort status", ST_A, 8'h08);
        @(posedge clk);
        #1;
        chk("overflow clear", 8'h00, {7'h0, ovf});
        chk("sck drive", 8'h00, {7'h0, sck_oe});
        $display("end abort");
        for (int i = 1; i >= 0; i--) begin
            bw(ST_A, {7'h0, i[0]});
            bw(CT_A, 8'h53);
            ss_n <= 1'b0;
            repeat (8) @(posedge clk);
            #1;
            chk("fault irq", {7'h0, i[0]}, {7'h0, irq});
            rchk("fault ctrl", CT_A, 8'h13);
            rchk("fault status", ST_A, st(4'h3, {2'b00, i[0]}));
            @(posedge clk);
            #1;
            chk("fault irq clear", 8'h00, {7'h0, irq});
            ss_n <= 1'b1;
        end
        $display("end master fault");
        bw(CT_A, 8'h44);
        bw(ST_A, 8'h00);
        sl(8'hA5, 8, 1'b1);
        rchk("slave status", ST_A, 8'h88);
        rchk("slave rx", DT_A, 8'hA5);
        sl(8'h3C, 3, 1'b1);
        rchk("slave fault", ST_A, 8'h18);
        sl(8'hFF, 8, 1'b0);
        rchk("ignored", ST_A, 8'h08);
        sl(8'h96, 8, 1'b1);
        rchk("resumed", ST_A, 8'h88);
        rchk("resumed rx", DT_A, 8'h96);
        $display("end slave");
        conclude();
    end
endmodule // spi_status_data_port_tb
`default_nettype wire
